/* File: common/sac_pkg.sv */
// package: register map, field layout and reset values of the converter configuration block
package sac_pkg;

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam logic [7:0] SAC_ADDR_ACC_CFG   = 8'hba;  // accumulator_config
  localparam logic [7:0] SAC_ADDR_CONV_CFG  = 8'hbc;  // converter_config
  localparam logic [7:0] SAC_ADDR_RES_LOW   = 8'hbe;  // result_low_byte
  localparam logic [7:0] SAC_ADDR_RES_HIGH  = 8'hbf;  // result_high_byte
  localparam logic [7:0] SAC_ADDR_CTRL      = 8'hc0;  // control
  localparam logic [7:0] SAC_ADDR_STATUS    = 8'hc1;  // interrupt status, write one to clear
  localparam logic [7:0] SAC_ADDR_MASK      = 8'hc2;  // interrupt mask

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int SAC_CTRL_ENABLE_BIT = 7;  // converter_enable
  localparam int SAC_CTRL_BURST_BIT  = 6;  // burst_mode_enable
  localparam int SAC_CTRL_START_BIT  = 4;  // write one: start conversion
  localparam int SAC_ACC_AE_BIT      = 6;  // accumulate_enable
  localparam int SAC_STAT_DONE_BIT   = 0;  // conversion_done_flag

  // ==========================================================================
  // reset values and timing counts
  // ==========================================================================
  localparam logic [7:0] SAC_CONV_CFG_RESET = 8'hf8;
  localparam logic [7:0] SAC_ACC_CFG_RESET  = 8'h00;
  localparam logic [1:0] SAC_TRACK_SAR_CLKS = 2'h3;   // extra tracking clocks in delayed mode
  localparam logic [3:0] SAC_BITS_10        = 4'ha;   // sar clocks of a 10-bit conversion
  localparam logic [3:0] SAC_BITS_8         = 4'h8;   // sar clocks of an 8-bit conversion
  localparam int         SAC_LJ_SHIFT       = 6;      // left justify of a 10-bit value in 16 bits

  // ==========================================================================
  // field layouts
  // ==========================================================================
  typedef struct packed {
    logic [4:0] sar_clock_divider;
    logic       eight_bit_mode_enable;
    logic       delayed_track_select;
    logic       input_gain_select;
  } sac_conv_cfg_t;

  typedef struct packed {
    logic       reserved;
    logic       accumulate_enable;
    logic [2:0] shift_justify_select;
    logic [2:0] burst_repeat_count;
  } sac_acc_cfg_t;

  typedef enum logic [2:0] {
    SAC_SJ_RIGHT0 = 3'h0,
    SAC_SJ_RIGHT1 = 3'h1,
    SAC_SJ_RIGHT2 = 3'h2,
    SAC_SJ_RIGHT3 = 3'h3,
    SAC_SJ_LEFT   = 3'h4
  } sac_sj_t;

  typedef enum logic {
    SAC_FLOW_IDLE,
    SAC_FLOW_RUN
  } sac_flow_t;

endpackage : sac_pkg

/* File: logic/sac_top.sv */
// module: configuration, sequencing and result formatting around a 10-bit sar converter
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - sar clock is the source clock divided by divider field plus one, field in bits 7:3.
// - without burst mode the divider is fed by the system clock.
// - with burst mode the divider is fed by the 20 mhz low-power oscillator.
// - bit 2 selects 8-bit conversions when one, 10-bit when zero.
// - track-mode bit clear: conversion starts right after the start event.
// - track-mode bit set: track three sar clocks, then convert.
// - bit 0 selects gain: zero gives half gain, one gives unity gain.
// - outside burst, accumulate enable picks latest result or running sum.
// - writing zero to the result pair clears the accumulated sum.
// - accumulate enable is write-only and always reads zero.
// - reserved top bit of accumulator config always reads zero.
// - shift/justify field: right with shift 0..3 or left justified, others unused.
// - in burst mode repeat code 0..5 runs 1,4,8,16,32,64 conversions.
// - 8-bit mode converts eight msbs, zeroes two lsbs, ends two sar clocks earlier.
// - done flag per conversion without burst, per whole burst with burst.
module sac_top
  import sac_pkg::*;
#(
  parameter int ACC_W = 16
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       lp_osc_clk,
  input  wire logic       start_event,
  input  wire logic [9:0] sar_sample,
  output logic            sar_conversion_clock,
  output logic            track_active,
  output logic            convert_active,
  output logic            eight_bit_mode,
  output logic            input_gain_select,
  output logic            irq
);

  // ==========================================================================
  // register storage
  // ==========================================================================
  sac_conv_cfg_t    conv_cfg;
  sac_acc_cfg_t     acc_cfg;
  logic             converter_enable;
  logic             burst_mode_enable;
  logic             done_status;
  logic             done_mask;
  logic [7:0]       res_high_stage;
  logic [ACC_W-1:0] acc;

  // ==========================================================================
  // register decode
  // ==========================================================================
  wire wr_conv_cfg = reg_wr && (reg_addr == SAC_ADDR_CONV_CFG);
  wire wr_acc_cfg  = reg_wr && (reg_addr == SAC_ADDR_ACC_CFG);
  wire wr_res_low  = reg_wr && (reg_addr == SAC_ADDR_RES_LOW);
  wire wr_res_high = reg_wr && (reg_addr == SAC_ADDR_RES_HIGH);
  wire wr_ctrl     = reg_wr && (reg_addr == SAC_ADDR_CTRL);
  wire wr_status   = reg_wr && (reg_addr == SAC_ADDR_STATUS);
  wire wr_mask     = reg_wr && (reg_addr == SAC_ADDR_MASK);
  wire sw_start    = wr_ctrl && reg_wdata[SAC_CTRL_START_BIT];

  // configuration registers; the reserved bit is never stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_cfg <= sac_conv_cfg_t'(SAC_CONV_CFG_RESET);
      acc_cfg  <= sac_acc_cfg_t'(SAC_ACC_CFG_RESET);
    end else begin
      if (wr_conv_cfg) begin
        conv_cfg <= sac_conv_cfg_t'(reg_wdata);
      end
      if (wr_acc_cfg) begin
        acc_cfg          <= sac_acc_cfg_t'(reg_wdata);
        acc_cfg.reserved <= 1'b0;
      end
    end
  end

  // control register and interrupt mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      converter_enable  <= 1'b0;
      burst_mode_enable <= 1'b0;
      done_mask         <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        converter_enable  <= reg_wdata[SAC_CTRL_ENABLE_BIT];
        burst_mode_enable <= reg_wdata[SAC_CTRL_BURST_BIT];
      end
      if (wr_mask) begin
        done_mask <= reg_wdata[SAC_STAT_DONE_BIT];
      end
    end
  end

  // ==========================================================================
  // source clock selection and sar clock divider
  // ==========================================================================
  // the oscillator is foreign to clk, so it is synchronised before its edge is seen;
  // 20 mhz sampled at 50 mhz leaves every rising edge visible
  logic lp_sync1;
  logic lp_sync2;
  logic lp_prev;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lp_sync1 <= 1'b0;
      lp_sync2 <= 1'b0;
      lp_prev  <= 1'b0;
    end else begin
      lp_sync1 <= lp_osc_clk;
      lp_sync2 <= lp_sync1;
      lp_prev  <= lp_sync2;
    end
  end

  wire       lp_rise  = lp_sync2 && !lp_prev;
  wire       src_tick = burst_mode_enable ? lp_rise : 1'b1;
  logic [4:0] div_cnt;
  wire       div_wrap = (div_cnt >= conv_cfg.sar_clock_divider);
  wire       sar_tick = src_tick && div_wrap;

  // a divider written smaller than the running count wraps at the next source tick
  // divider counts source ticks; one sar clock each divider+1 ticks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt              <= 5'h00;
      sar_conversion_clock <= 1'b0;
    end else if (src_tick) begin
      div_cnt              <= div_wrap ? 5'h00 : div_cnt + 5'h01;
      sar_conversion_clock <= div_wrap;
    end else begin
      sar_conversion_clock <= 1'b0;
    end
  end

  // ==========================================================================
  // sample input capture
  // ==========================================================================
  // comparator result arrives from the analog side, so it is resynchronised
  logic [9:0] sample_sync1;
  logic [9:0] sample_sync2;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_sync1 <= 10'h000;
      sample_sync2 <= 10'h000;
    end else begin
      sample_sync1 <= sar_sample;
      sample_sync2 <= sample_sync1;
    end
  end

  // ==========================================================================
  // sample word hand-over
  // ==========================================================================
  // bits of one comparator word may leave the flops above in different cycles;
  // a word is only taken once it has read the same on two clocks in a row
  logic [9:0] sample_sync3;
  logic [9:0] sample_word;
  wire        sample_steady = (sample_sync2 == sample_sync3);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_sync3 <= 10'h000;
      sample_word  <= 10'h000;
    end else begin
      sample_sync3 <= sample_sync2;
      if (sample_steady) begin
        sample_word <= sample_sync3;
      end
    end
  end

  // ==========================================================================
  // conversion sequencer
  // ==========================================================================
  sac_flow_t  flow;
  logic       tracking;
  logic [3:0] step_cnt;
  logic [6:0] conv_left;

  // conversions in one start: one outside burst, the repeat code inside it
  logic [6:0] burst_len;
  always_comb begin
    unique case (acc_cfg.burst_repeat_count)
      3'h1:    burst_len = 7'd4;
      3'h2:    burst_len = 7'd8;
      3'h3:    burst_len = 7'd16;
      3'h4:    burst_len = 7'd32;
      3'h5:    burst_len = 7'd64;
      default: burst_len = 7'd1;
    endcase
  end

  // a start that arrives while a run is in progress is dropped, not queued
  // burst powers the converter itself, otherwise the enable must be on
  wire        start_ok   = (flow == SAC_FLOW_IDLE) && (converter_enable || burst_mode_enable);
  wire        start_req  = start_ok && (sw_start || start_event);
  wire [6:0]  start_len  = burst_mode_enable ? burst_len : 7'd1;
  wire [3:0]  conv_bits  = conv_cfg.eight_bit_mode_enable ? SAC_BITS_8 : SAC_BITS_10;
  wire        track_done = tracking && sar_tick && (step_cnt[1:0] == SAC_TRACK_SAR_CLKS - 2'h1);
  wire        conv_done  = (flow == SAC_FLOW_RUN) && !tracking && sar_tick
                           && (step_cnt == conv_bits - 4'h1);
  wire        last_conv  = conv_done && (conv_left == 7'd1);
  wire        first_conv = (conv_left == start_len);

  // tracking phase, then one sar clock per result bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flow      <= SAC_FLOW_IDLE;
      tracking  <= 1'b0;
      step_cnt  <= 4'h0;
      conv_left <= 7'd0;
    end else if (start_req) begin
      flow      <= SAC_FLOW_RUN;
      tracking  <= conv_cfg.delayed_track_select;
      step_cnt  <= 4'h0;
      conv_left <= start_len;
    end else if (flow == SAC_FLOW_RUN) begin
      if (track_done) begin
        tracking <= 1'b0;
        step_cnt <= 4'h0;
      end else if (conv_done) begin
        step_cnt  <= 4'h0;
        conv_left <= conv_left - 7'd1;
        tracking  <= conv_cfg.delayed_track_select;
        if (last_conv) begin
          flow <= SAC_FLOW_IDLE;
        end
      end else if (sar_tick) begin
        step_cnt <= step_cnt + 4'h1;
      end
    end
  end

  // ==========================================================================
  // accumulator
  // ==========================================================================
  wire [9:0]       sample_fmt = conv_cfg.eight_bit_mode_enable ? {sample_word[9:2], 2'b00} : sample_word;
  wire             add_mode   = burst_mode_enable ? !first_conv : acc_cfg.accumulate_enable;
  wire [ACC_W-1:0] sample_ext = ACC_W'(sample_fmt);
  wire [ACC_W-1:0] next_acc   = add_mode ? acc + sample_ext : sample_ext;

  // sixty-four full-scale ten-bit results still fit in sixteen bits, so a burst sum never wraps; a running sum outside burst can
  // software load of the pair takes priority; a zero pair clears the sum
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc            <= '0;
      res_high_stage <= 8'h00;
    end else begin
      if (wr_res_high) begin
        res_high_stage <= reg_wdata;
      end
      if (wr_res_low) begin
        acc <= ACC_W'({res_high_stage, reg_wdata});
      end else if (conv_done) begin
        acc <= next_acc;
      end
    end
  end

  // ==========================================================================
  // result formatting
  // ==========================================================================
  // reserved justify codes fall to the unshifted view rather than an undefined one
  // left justify only makes sense for a single 10-bit result, upper sum bits fall off
  logic [ACC_W-1:0] result_fmt;
  always_comb begin
    unique case (acc_cfg.shift_justify_select)
      SAC_SJ_RIGHT1: result_fmt = acc >> 1;
      SAC_SJ_RIGHT2: result_fmt = acc >> 2;
      SAC_SJ_RIGHT3: result_fmt = acc >> 3;
      SAC_SJ_LEFT:   result_fmt = acc << SAC_LJ_SHIFT;
      default:       result_fmt = acc;
    endcase
  end

  // ==========================================================================
  // completion flag and interrupt
  // ==========================================================================
  wire done_event = conv_done && (burst_mode_enable ? last_conv : 1'b1);

  // a completion in the clear cycle wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_status <= 1'b0;
    end else if (done_event) begin
      done_status <= 1'b1;
    end else if (wr_status && reg_wdata[SAC_STAT_DONE_BIT]) begin
      done_status <= 1'b0;
    end
  end

  assign irq = done_status && done_mask;

  // ==========================================================================
  // read path
  // ==========================================================================
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      SAC_ADDR_CONV_CFG: rd_mux = conv_cfg;
      SAC_ADDR_ACC_CFG:  rd_mux = {2'b00, acc_cfg.shift_justify_select, acc_cfg.burst_repeat_count};
      SAC_ADDR_RES_LOW:  rd_mux = result_fmt[7:0];
      SAC_ADDR_RES_HIGH: rd_mux = result_fmt[15:8];
      SAC_ADDR_CTRL:     rd_mux = {converter_enable, burst_mode_enable, 1'b0, flow == SAC_FLOW_RUN, 4'h0};
      SAC_ADDR_STATUS:   rd_mux = {7'h00, done_status};
      SAC_ADDR_MASK:     rd_mux = {7'h00, done_mask};
      default:           rd_mux = 8'h00;
    endcase
  end

  // a zero outside the read slot lets several readers share one return bus
  // read data stand in the cycle after the strobe only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================================
  // analog-side controls
  // ==========================================================================
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      track_active      <= 1'b0;
      convert_active    <= 1'b0;
      eight_bit_mode    <= 1'b0;
      input_gain_select <= 1'b0;
    end else begin
      track_active      <= (flow == SAC_FLOW_RUN) && tracking;
      convert_active    <= (flow == SAC_FLOW_RUN) && !tracking;
      eight_bit_mode    <= conv_cfg.eight_bit_mode_enable;
      input_gain_select <= conv_cfg.input_gain_select;
    end
  end

endmodule // sac_top

/* File: tb/sac_top_assertions.sv */
// checker: port-level assertions for the converter configuration block
`timescale 1ns/10ps
module sac_top_assertions
  import sac_pkg::*;
#(
  parameter int ACC_W = 16
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       lp_osc_clk,
  input wire logic       start_event,
  input wire logic [9:0] sar_sample,
  input wire logic       sar_conversion_clock,
  input wire logic       track_active,
  input wire logic       convert_active,
  input wire logic       eight_bit_mode,
  input wire logic       input_gain_select,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // register bus
  // ==========================================================================
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the read slot");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_acc_top_zero: assert property ($past(reg_rd) && $past(reg_addr) == SAC_ADDR_ACC_CFG |-> reg_rdata[7:6] == 2'h0)
    else $error("accumulator config top bits not zero");
  a_cfg_readback: assert property (reg_rd && reg_addr == SAC_ADDR_CONV_CFG && $past(reg_wr, 2) && $past(reg_addr, 2) == SAC_ADDR_CONV_CFG |=> reg_rdata == $past(reg_wdata, 3))
    else $error("converter config readback differs");
  // copies of config bits follow a write within two edges
  a_cfg_copy_out: assert property (reg_wr && reg_addr == SAC_ADDR_CONV_CFG |-> ##2 (input_gain_select == $past(reg_wdata[0], 2) && eight_bit_mode == $past(reg_wdata[2], 2)))
    else $error("gain or width copy wrong");
  // ==========================================================================
  // sequencing and interrupt
  // ==========================================================================
  a_track_convert_excl: assert property (!(track_active && convert_active))
    else $error("tracking and converting at once");
  a_done_after_conv: assert property ($rose(irq) && !$past(reg_wr) |-> $past(convert_active) || $past(convert_active, 2))
    else $error("done raised without a conversion");
  a_irq_clear_w1c: assert property (reg_wr && reg_addr == SAC_ADDR_STATUS && reg_wdata[0] && !convert_active && !track_active |=> !irq)
    else $error("interrupt not cleared by write one");
  a_mask_gates_irq: assert property (reg_wr && reg_addr == SAC_ADDR_MASK && !reg_wdata[0] |=> !irq)
    else $error("masked interrupt still high");
endmodule // sac_top_assertions

bind sac_top sac_top_assertions #(.ACC_W(ACC_W)) u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lp_osc_clk(lp_osc_clk),
  .start_event(start_event), .sar_sample(sar_sample), .sar_conversion_clock(sar_conversion_clock),
  .track_active(track_active), .convert_active(convert_active), .eight_bit_mode(eight_bit_mode),
  .input_gain_select(input_gain_select), .irq(irq));

/* File: tb/tb_sar_adc_config_accumulator.sv */
// testbench: register-level scenarios for the converter configuration block
`timescale 1ns/10ps
module tb_sar_adc_config_accumulator import sac_pkg::*;;
  logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, lp_osc_clk = 1'b0;
  logic        start_event = 1'b0, lp_run = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv, ctrl;
  logic [9:0]  sar_sample = 10'h000;
  logic        sar_conversion_clock, track_active, convert_active, eight_bit_mode, input_gain_select, irq;
  logic [15:0] res, ticks, trk, cnv, first, last, n;
  int          n_mismatch = 0, checked = 0;

  // ==========================================================================
  // clocks and device
  // ==========================================================================
  always #10 clk = ~clk;
  // 20 mhz oscillator, only running when asked, so a wrong divider source shows up as missing ticks;
  // offset by 3 ns so its edges never meet a clk edge
  initial begin
    #3;
    forever #25 if (lp_run) lp_osc_clk = ~lp_osc_clk;
  end
  sac_top #(.ACC_W(16)) u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lp_osc_clk(lp_osc_clk), .start_event(start_event),
    .sar_sample(sar_sample), .sar_conversion_clock(sar_conversion_clock), .track_active(track_active),
    .convert_active(convert_active), .eight_bit_mode(eight_bit_mode), .input_gain_select(input_gain_select),
    .irq(irq));

  // ==========================================================================
  // bus and check tasks
  // ==========================================================================
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic rd_res;
    rd(SAC_ADDR_RES_HIGH);
    res[15:8] = rv;
    rd(SAC_ADDR_RES_LOW);
    res[7:0] = rv;
  endtask
  task automatic start(input bit pin);
    if (pin) begin
      @(posedge clk);
      start_event <= 1'b1;
      @(posedge clk);
      start_event <= 1'b0;
    end else wr(SAC_ADDR_CTRL, ctrl | 8'h10);
  endtask
  // counts sar ticks and tracking cycles until the interrupt or the limit
  task automatic wait_done(input int lim);
    int cyc;
    cyc = 0;
    ticks = 16'h0000;
    trk = 16'h0000;
    cnv = 16'h0000;
    while (irq !== 1'b1 && cyc < lim) begin
      @(posedge clk);
      #1;
      cyc++;
      if (sar_conversion_clock === 1'b1) begin
        if (ticks == 16'h0000) first = 16'(cyc);
        last = 16'(cyc);
        ticks++;
      end
      if (track_active === 1'b1) trk++;
      if (convert_active === 1'b1) cnv++;
    end
  endtask
  task automatic conv(input bit pin);
    start(pin);
    wait_done(4000);
    cmp(irq, 16'h0001);
  endtask
  task automatic clr;
    wr(SAC_ADDR_STATUS, 8'h01);
    cmp(irq, 16'h0000);
  endtask
  task automatic final_report;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(SAC_ADDR_CONV_CFG);
    cmp(rv, SAC_CONV_CFG_RESET);
    cmp(eight_bit_mode, 16'h0000);
    cmp(input_gain_select, 16'h0000);
    rd(SAC_ADDR_ACC_CFG);
    cmp(rv, SAC_ACC_CFG_RESET);
    rd(8'h00);
    cmp(rv, 16'h0000);
    wr(SAC_ADDR_ACC_CFG, 8'hc0);
    rd(SAC_ADDR_ACC_CFG);
    cmp(rv, 16'h0000);
    // divider 1, 8-bit, normal tracking, unity gain, divider fed by clk only
    wr(SAC_ADDR_CONV_CFG, 8'h0d);
    rd(SAC_ADDR_CONV_CFG);
    cmp(rv, 16'h000d);
    cmp(eight_bit_mode, 16'h0001);
    cmp(input_gain_select, 16'h0001);
    wr(SAC_ADDR_MASK, 8'h01);
    ctrl = 8'h80;
    wr(SAC_ADDR_CTRL, ctrl);
    sar_sample <= 10'h2ff;
    conv(0);
    cmp(ticks, 16'h0008);
    cmp(trk, 16'h0000);
    cmp(last - first, 16'h000e);
    rd_res;
    cmp(res, 16'h02fc);
    clr;
    // divider 0, 10-bit, delayed tracking; accumulate from a cleared pair
    wr(SAC_ADDR_CONV_CFG, 8'h03);
    sar_sample <= 10'h155;
    wr(SAC_ADDR_RES_HIGH, 8'h00);
    cmp(eight_bit_mode, 16'h0000);
    wr(SAC_ADDR_RES_LOW, 8'h00);
    rd_res;
    cmp(res, 16'h0000);
    conv(1);
    cmp(ticks, 16'h000d);
    cmp(trk, 16'h0003);
    cmp(cnv, 16'h000a);
    clr;
    conv(0);
    rd_res;
    cmp(res, 16'h02aa);
    wr(SAC_ADDR_MASK, 8'h00);
    cmp(irq, 16'h0000);
    rd(SAC_ADDR_STATUS);
    cmp(rv, 16'h0001);
    wr(SAC_ADDR_MASK, 8'h01);
    cmp(irq, 16'h0001);
    clr;
    for (int s = 0; s < 5; s++) begin
      wr(SAC_ADDR_ACC_CFG, 8'(s * 8));
      rd_res;
      cmp(res, (s == 4) ? 16'h02aa << SAC_LJ_SHIFT : 16'h02aa >> s);
    end
    wr(SAC_ADDR_ACC_CFG, 8'h00);
    conv(0);
    rd_res;
    cmp(res, 16'h0155);
    clr;
    // burst: no ticks while the oscillator stands, then repeat codes 0 to 5
    wr(SAC_ADDR_CONV_CFG, 8'h01);
    ctrl = 8'hc0;
    wr(SAC_ADDR_CTRL, ctrl);
    start(0);
    wait_done(60);
    cmp(ticks, 16'h0000);
    lp_run = 1'b1;
    wait_done(4000);
    cmp(ticks, 16'h000a);
    clr;
    for (int r = 0; r < 6; r++) begin
      n = (r == 0) ? 16'h0001 : 16'h0002 << r;
      wr(SAC_ADDR_ACC_CFG, 8'(r));
      conv(0);
      cmp(ticks, 16'h000a * n);
      rd_res;
      cmp(res, 16'h0155 * n);
      clr;
    end
    wr(SAC_ADDR_ACC_CFG, 8'h00);
    ctrl = 8'h80;
    wr(SAC_ADDR_CTRL, ctrl);
    // half gain and 8-bit width must follow a later write, not only reset
    wr(SAC_ADDR_CONV_CFG, 8'h04);
    rd(SAC_ADDR_CONV_CFG);
    cmp(rv, 16'h0004);
    cmp(input_gain_select, 16'h0000);
    cmp(eight_bit_mode, 16'h0001);
    final_report;
  end

  // watchdog, well beyond the few thousand cycles the scenarios need
  initial begin
    #600000;
    n_mismatch++;
    final_report;
  end
endmodule // tb_sar_adc_config_accumulator
